// File: src/wko_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - bypass clear: all checksums and FCS must agree
// - bypass set: only FCS checked
// - offloaded ARP sunk or passed per forward bit
// - offloaded NS sunk or passed per forward bit
// - NA source from match set or target
// - sticky NS seen flag, write-one clears
// - sticky ARP seen flag, write-one clears
// - sticky IPv6 SYN seen flag
// - sticky IPv4 SYN seen flag
// - resume may clear both SYN seen flags
// - NS reply and matching only when enabled
// - ARP reply only when enabled
// - IPv6 SYN wake only when enabled
// - IPv4 SYN wake only when enabled
// - resume may clear both SYN wake enables
// - two 128-bit match sets, four words each
// - NS matching needs own, multicast, broadcast destination
// - compare IPv6 destination against both sets
// - solicited-node: compare set[127:104] to low 24
// - first received byte in top word bits 31:24
module wko_ctrl
  import wko_pkg::*;
(
  input  wire logic          i_clk,       // 20 MHz clock
  input  wire logic          i_arst_n,    // async reset, active low
  input  wire logic          i_awvalid,   // write address valid
  output logic               o_awready,   // write address ready
  input  wire logic [11:0]   i_awaddr,    // write byte address
  input  wire logic          i_wvalid,    // write data valid
  output logic               o_wready,    // write data ready
  input  wire logic [31:0]   i_wdata,     // write data
  input  wire logic [3:0]    i_wstrb,     // write byte enables
  output logic               o_bvalid,    // write response valid
  input  wire logic          i_bready,    // write response ready
  output logic [1:0]         o_bresp,     // write response code
  input  wire logic          i_arvalid,   // read address valid
  output logic               o_arready,   // read address ready
  input  wire logic [11:0]   i_araddr,    // read byte address
  output logic               o_rvalid,    // read data valid
  input  wire logic          i_rready,    // read data ready
  output logic [31:0]        o_rdata,     // read data
  output logic [1:0]         o_rresp,     // read response code
  input  wire logic          i_rx_valid,  // frame summary strobe
  input  wire wko_frame_type i_frame,     // frame summary
  input  wire logic          i_resume_done, // resume completed pulse
  output wko_result_type     o_result     // per-frame decision
);

  wko_state_type s_reg;
  wko_state_type s_next;

  logic          aw_hs;
  logic          w_hs;
  logic          ar_hs;
  logic          sn_addr;
  logic [1:0]    hit;
  logic [9:0]    wr_idx;
  logic [31:0]   wr_data;
  logic [31:0]   wr_mask;
  logic [1:0]    set_wsel;
  logic [1:0]    set_rsel;
  logic [31:0]   set_wword [2];
  logic [31:0]   set_rword [2];

  // a waiting response blocks new writes: one write in flight at a time
  assign o_awready = ~s_reg.aw_got & ~s_reg.bvalid;
  assign o_wready  = ~s_reg.w_got & ~s_reg.bvalid;
  assign o_arready = ~s_reg.rvalid;
  assign aw_hs     = i_awvalid & o_awready;
  assign w_hs      = i_wvalid & o_wready;
  assign ar_hs     = i_arvalid & o_arready;

  assign o_bvalid = s_reg.bvalid;
  assign o_bresp  = s_reg.bresp;
  assign o_rvalid = s_reg.rvalid;
  assign o_rdata  = s_reg.rdata;
  assign o_rresp  = s_reg.rresp;
  assign o_result = s_reg.res;

  function automatic logic set_sel(input logic [9:0] idx,
                                   input logic [11:0] ofs);
    set_sel = idx[9:2] == ofs[11:4];
  endfunction

  // held copies win once a channel has been taken ahead of its partner
  assign wr_idx  = s_reg.aw_got ? s_reg.aw_idx : i_awaddr[11:2];
  assign wr_data = s_reg.w_got ? s_reg.wdata : i_wdata;

  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign wr_mask[b*8 +: 8] =
      {8{s_reg.w_got ? s_reg.wstrb[b] : i_wstrb[b]}};
  end

  // solicited-node destinations match only on the low 24 bits
  assign sn_addr = i_frame.v6_dst[127:24] == WKO_SOLICIT_PFX;

  // one pass per match set: header compare and register access
  for (genvar g = 0; g < 2; g++)
  begin : g_match
    localparam logic [11:0] BASE = (g == 0) ? WKO_SET0_OFS :
                                              WKO_SET1_OFS;
    // header bytes arrive msb first, same order as set words
    assign hit[g] = sn_addr ?
      (s_reg.dst[g][127:104] == i_frame.v6_dst[23:0]) :
      (s_reg.dst[g] == i_frame.v6_dst);
    // word 0 carries bits 31:0, word 3 the first bytes on the wire
    assign set_wsel[g]  = set_sel(wr_idx, BASE);
    assign set_rsel[g]  = set_sel(i_araddr[11:2], BASE);
    assign set_rword[g] = s_reg.dst[g][{i_araddr[3:2], 5'h00} +: 32];
    // byte lanes left unstrobed keep their old contents
    assign set_wword[g] =
      (s_reg.dst[g][{wr_idx[1:0], 5'h00} +: 32] & ~wr_mask) |
      (wr_data & wr_mask);
  end

  always_comb
  begin
    logic [9:0]   wa;
    logic [31:0]  wd;
    logic [31:0]  wm;
    logic [31:0]  clr;
    logic [31:0]  set;
    logic [9:0]   ra;
    logic         wr_go;
    logic         integ_ok;
    logic         frame_ok;
    logic         ns_en;
    logic         ns_hit;
    logic         ns_take;
    logic         arp_take;
    logic [6:0]   wsh;
    wa       = wr_idx;
    wd       = wr_data;
    wm       = wr_mask;
    clr      = '0;
    set      = '0;
    ra       = i_araddr[11:2];
    wr_go    = (s_reg.aw_got | aw_hs) & (s_reg.w_got | w_hs);
    wsh      = {wa[1:0], 5'h00};
    integ_ok = 1'b0;
    frame_ok = 1'b0;
    ns_en    = s_reg.ctrl[WKO_NS_EN_BIT];
    ns_hit   = 1'b0;
    ns_take  = 1'b0;
    arp_take = 1'b0;
    s_next   = s_reg;
    s_next.res.pass_rx   = 1'b0;
    s_next.res.sink      = 1'b0;
    s_next.res.arp_reply = 1'b0;
    s_next.res.ns_reply  = 1'b0;
    s_next.res.wake      = 1'b0;

    // write channel: address and data taken in either order
    if (aw_hs)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_idx = i_awaddr[11:2];
    end
    if (w_hs)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = i_wdata;
      s_next.wstrb = i_wstrb;
    end
    if (wr_go)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = WKO_RESP_OKAY;
      if (wa == WKO_CTRL_OFS[11:2])
      begin
        s_next.ctrl = (s_reg.ctrl & ~(WKO_CTRL_RW_MASK & wm)) |
                      (wd & WKO_CTRL_RW_MASK & wm);
        clr = wd & WKO_CTRL_W1C_MASK & wm;
      end
      else if (wa == WKO_RESUME_OFS[11:2])
      begin
        s_next.resume = (s_reg.resume & ~wm[1:0]) |
                        (wd[1:0] & wm[1:0]);
      end
      else if (set_wsel[0])
      begin
        s_next.dst[0][wsh +: 32] = set_wword[0];
      end
      else if (set_wsel[1])
      begin
        s_next.dst[1][wsh +: 32] = set_wword[1];
      end
      else
      begin
        s_next.bresp = WKO_RESP_DECERR;
      end
    end
    if (s_reg.bvalid & i_bready)
    begin
      s_next.bvalid = 1'b0;
    end

    // read channel: one read in flight, data held until taken
    if (ar_hs)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = WKO_RESP_OKAY;
      if (ra == WKO_CTRL_OFS[11:2])
      begin
        s_next.rdata = s_reg.ctrl;
      end
      else if (ra == WKO_RESUME_OFS[11:2])
      begin
        s_next.rdata = {30'h0, s_reg.resume};
      end
      else if (set_rsel[0])
      begin
        s_next.rdata = set_rword[0];
      end
      else if (set_rsel[1])
      begin
        s_next.rdata = set_rword[1];
      end
      else
      begin
        s_next.rdata = 32'h0000_0000;
        s_next.rresp = WKO_RESP_DECERR;
      end
    end
    else if (s_reg.rvalid & i_rready)
    begin
      s_next.rvalid = 1'b0;
    end

    // frame decisions
    if (i_rx_valid)
    begin
      integ_ok = i_frame.fcs_ok &
        (s_reg.ctrl[WKO_BYPASS_BIT] |
         (i_frame.ip_csum_ok & i_frame.l4_csum_ok));
      frame_ok = integ_ok & i_frame.eth_dst_ok;
      // match sets are idle while neighbor replies are off
      s_next.res.ns_match = ns_en ? hit : 2'h0;
      ns_hit  = ns_en & (|hit);
      // flags follow integrity and Ethernet destination; reply enables gate the answer
      unique case (i_frame.kind)
        WKO_K_ARP:
        begin
          set[WKO_ARP_SEEN_BIT] = frame_ok;
          arp_take = frame_ok & i_frame.targets_me &
                     s_reg.ctrl[WKO_ARP_EN_BIT];
          s_next.res.arp_reply = arp_take;
          s_next.res.pass_rx = ~arp_take |
                               s_reg.ctrl[WKO_ARP_FWD_BIT];
          s_next.res.sink = arp_take &
                            ~s_reg.ctrl[WKO_ARP_FWD_BIT];
        end
        WKO_K_NS:
        begin
          set[WKO_NS_SEEN_BIT] = frame_ok;
          ns_take = frame_ok & ns_hit;
          s_next.res.ns_reply = ns_take;
          s_next.res.pass_rx = ~ns_take |
                               s_reg.ctrl[WKO_NS_FWD_BIT];
          s_next.res.sink = ns_take &
                            ~s_reg.ctrl[WKO_NS_FWD_BIT];
          if (ns_take)
          begin
            if (s_reg.ctrl[WKO_NA_SEL_BIT])
            begin
              // set 0 wins when both sets hit
              s_next.res.na_src = hit[0] ? s_reg.dst[0] :
                                           s_reg.dst[1];
            end
            else
            begin
              s_next.res.na_src = i_frame.ns_target;
            end
          end
        end
        WKO_K_V4_SYN:
        begin
          set[WKO_V4_SEEN_BIT] = frame_ok;
          s_next.res.wake = frame_ok &
                            s_reg.ctrl[WKO_V4_WAKE_BIT];
          s_next.res.pass_rx = 1'b1;
        end
        WKO_K_V6_SYN:
        begin
          set[WKO_V6_SEEN_BIT] = frame_ok;
          s_next.res.wake = frame_ok &
                            s_reg.ctrl[WKO_V6_WAKE_BIT];
          s_next.res.pass_rx = 1'b1;
        end
        WKO_K_OTHER:
        begin
          s_next.res.pass_rx = 1'b1;
        end
        default:
        begin
          s_next.res.pass_rx = 1'b1;
        end
      endcase
    end

    // resume overrides a same-cycle software write of the enables
    if (i_resume_done)
    begin
      if (s_reg.resume[WKO_RES_CLR_FLAGS_BIT])
      begin
        clr[WKO_V6_SEEN_BIT] = 1'b1;
        clr[WKO_V4_SEEN_BIT] = 1'b1;
      end
      if (s_reg.resume[WKO_RES_CLR_EN_BIT])
      begin
        s_next.ctrl[WKO_V6_WAKE_BIT] = 1'b0;
        s_next.ctrl[WKO_V4_WAKE_BIT] = 1'b0;
      end
    end

    // sets applied after clears so no event is lost
    s_next.ctrl = (s_next.ctrl & ~clr) | set;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_reg        <= '0;
      s_reg.ctrl   <= WKO_CTRL_RST;
      s_reg.resume <= WKO_RESUME_RST;
      s_reg.dst    <= {WKO_ADDR_RST, WKO_ADDR_RST};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule // wko_ctrl

// File: src/wko_pkg.sv
package wko_pkg;
  // register byte offsets
  localparam logic [11:0] WKO_CTRL_OFS   = 12'h600;
  localparam logic [11:0] WKO_RESUME_OFS = 12'h604;
  localparam logic [11:0] WKO_SET0_OFS   = 12'h610;
  localparam logic [11:0] WKO_SET1_OFS   = 12'h650;
  // control and status field positions
  localparam int WKO_BYPASS_BIT  = 31;
  localparam int WKO_ARP_FWD_BIT = 10;
  localparam int WKO_NS_FWD_BIT  = 9;
  localparam int WKO_NA_SEL_BIT  = 8;
  localparam int WKO_NS_SEEN_BIT = 7;
  localparam int WKO_ARP_SEEN_BIT = 6;
  localparam int WKO_V6_SEEN_BIT = 5;
  localparam int WKO_V4_SEEN_BIT = 4;
  localparam int WKO_NS_EN_BIT   = 3;
  localparam int WKO_ARP_EN_BIT  = 2;
  localparam int WKO_V6_WAKE_BIT = 1;
  localparam int WKO_V4_WAKE_BIT = 0;
  localparam int WKO_RES_CLR_FLAGS_BIT = 0;
  localparam int WKO_RES_CLR_EN_BIT    = 1;
  localparam logic [31:0] WKO_CTRL_RW_MASK  = 32'h8000_070f;
  localparam logic [31:0] WKO_CTRL_W1C_MASK = 32'h0000_00f0;
  localparam logic [31:0] WKO_RESUME_MASK   = 32'h0000_0003;
  // reset values
  localparam logic [31:0]  WKO_CTRL_RST   = 32'h0000_0000;
  localparam logic [1:0]   WKO_RESUME_RST = 2'h0;
  localparam logic [127:0] WKO_ADDR_RST   = 128'h0;
  // solicited-node multicast prefix, upper 104 bits
  localparam logic [103:0] WKO_SOLICIT_PFX =
    104'hff02_0000_0000_0000_0000_0001_ff;
  localparam logic [1:0] WKO_RESP_OKAY   = 2'h0;
  localparam logic [1:0] WKO_RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    WKO_K_OTHER,
    WKO_K_ARP,
    WKO_K_NS,
    WKO_K_V4_SYN,
    WKO_K_V6_SYN
  } wko_kind_type;

  // per-frame summary from the receive path
  typedef struct packed {
    wko_kind_type   kind;
    logic           targets_me;
    logic           eth_dst_ok;
    logic           fcs_ok;
    logic           ip_csum_ok;
    logic           l4_csum_ok;
    logic [127:0]   v6_dst;
    logic [127:0]   ns_target;
  } wko_frame_type;

  typedef struct packed {
    logic           pass_rx;
    logic           sink;
    logic           arp_reply;
    logic           ns_reply;
    logic           wake;
    logic [1:0]     ns_match;
    logic [127:0]   na_src;
  } wko_result_type;

  typedef struct packed {
    logic [31:0]          ctrl;
    logic [1:0]           resume;
    logic [1:0][127:0]    dst;
    logic                 aw_got;
    logic [9:0]           aw_idx;
    logic                 w_got;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    wko_result_type       res;
  } wko_state_type;
endpackage

// File: verif/wko_ctrl_monitor.sv
`timescale 1ns/1ps
module wko_ctrl_monitor
  import wko_pkg::*;
(
  input wire logic           i_clk,      // clock
  input wire logic           i_arst_n,   // reset, active low
  input wire logic           i_awvalid,  // aw valid
  input wire logic           o_awready,  // aw ready
  input wire logic           i_wvalid,   // w valid
  input wire logic           o_wready,   // w ready
  input wire logic           o_bvalid,   // b valid
  input wire logic           i_arvalid,  // ar valid
  input wire logic           o_arready,  // ar ready
  input wire logic           o_rvalid,   // r valid
  input wire logic           i_rready,   // r ready
  input wire logic [31:0]    o_rdata,    // read data
  input wire logic           i_rx_valid, // frame strobe
  input wire wko_frame_type  i_frame,    // frame summary
  input wire wko_result_type o_result    // decision
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic syn = i_frame.kind inside {WKO_K_V4_SYN, WKO_K_V6_SYN};

  AST_WR_ANSWER: assert property
    (i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid)
    else $error("write not answered next cycle");
  AST_RD_ANSWER: assert property
    (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered next cycle");
  AST_RD_HOLD: assert property
    (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read answer dropped before ready");
  AST_NO_FRAME: assert property
    (!i_rx_valid |=> o_result[134:130] == 5'h0)
    else $error("decision pulse without a frame");
  AST_FCS: assert property
    (i_rx_valid && !i_frame.fcs_ok |=> o_result[132:130] == 3'h0)
    else $error("reply or wake on bad fcs");
  AST_SINK: assert property
    (o_result.sink |-> !o_result.pass_rx)
    else $error("frame both sunk and passed");
  AST_ARP: assert property
    (i_rx_valid && i_frame.kind != WKO_K_ARP |=> !o_result.arp_reply)
    else $error("arp reply to another kind");
  AST_NS_ETH: assert property
    (i_rx_valid && !i_frame.eth_dst_ok |=> !o_result.ns_reply)
    else $error("ns reply to foreign ethernet address");
  AST_NS_MATCH: assert property
    (o_result.ns_reply |-> o_result.ns_match != 2'h0)
    else $error("ns reply with no set hit");
  AST_SYN: assert property
    (i_rx_valid |=> ($past(syn) ? o_result.pass_rx && !o_result.sink
                                : !o_result.wake))
    else $error("syn handling wrong");
endmodule // wko_ctrl_monitor

bind wko_ctrl wko_ctrl_monitor i_wko_ctrl_monitor (.i_clk, .i_arst_n,
  .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_arvalid,
  .o_arready, .o_rvalid, .i_rready, .o_rdata, .i_rx_valid, .i_frame,
  .o_result);

// File: verif/wko_rx_model.sv
`timescale 1ns/1ps
module wko_rx_model
  import wko_pkg::*;
(
  input  wire logic    i_clk,      // clock
  output logic         o_rx_valid, // frame strobe
  output wko_frame_type o_frame    // frame summary
);
  initial
  begin
    o_rx_valid = 1'b0;
    o_frame = '0;
  end
  task automatic send(input wko_frame_type f);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_frame <= f;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    // stale summary inverted so nothing leans on it
    o_frame <= ~f;
  endtask
endmodule // wko_rx_model

// File: verif/wko_ctrl_tb_top.sv
`timescale 1ns/1ps
module wko_ctrl_tb_top
  import wko_pkg::*;
();
  logic           i_clk = 1'b0;
  logic           i_arst_n = 1'b0;
  logic           i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic           i_arvalid = 1'b0, i_rready = 1'b0;
  logic           i_resume_done = 1'b0;
  logic [11:0]    i_awaddr = 12'h0, i_araddr = 12'h0;
  logic [31:0]    i_wdata = 32'h0, rv;
  logic [3:0]     i_wstrb = 4'hf;
  logic           o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]     o_bresp, o_rresp, rs;
  logic [31:0]    o_rdata;
  logic           i_rx_valid;
  wko_frame_type  i_frame;
  wko_result_type o_result;
  logic [127:0]   adr = 128'hfe80_0000_0000_0000_0211_22ff_fe33_4455;
  logic [127:0]   tgt = 128'h2001_0db8_0000_0000_0000_0000_0000_0042;
  logic [127:0]   dst;
  int             n_errors = 0, total_checks = 0;

  always #25 i_clk = ~i_clk;

  wko_rx_model i_wko_rx_model (.i_clk, .o_rx_valid(i_rx_valid),
    .o_frame(i_frame));
  wko_ctrl i_wko_ctrl (.i_clk, .i_arst_n, .i_awvalid, .o_awready,
    .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid,
    .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
    .i_rready, .o_rdata, .o_rresp, .i_rx_valid, .i_frame,
    .i_resume_done, .o_result);

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hung(input int n);
    if (n >= 20)
    begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_bready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    rs = o_bresp;
    i_bready <= 1'b0;
    hung(n);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    rv = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
    hung(n);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
    chk(rs, WKO_RESP_OKAY);
  endtask
  // kind, {targets_me,eth,fcs,ip,l4}, {pass,sink,arp,ns,wake}
  task automatic frm(input wko_kind_type k, input logic [4:0] ok,
                     input logic [4:0] e);
    i_wko_rx_model.send({k, ok, dst, tgt});
    #1;
    chk(o_result[134:130], e);
  endtask
  task automatic rsm();
    @(posedge i_clk);
    i_resume_done <= 1'b1;
    @(posedge i_clk);
    i_resume_done <= 1'b0;
  endtask

  task automatic t_regs();
    rc(WKO_CTRL_OFS, WKO_CTRL_RST);
    rc(WKO_RESUME_OFS, 32'h0);
    rc(WKO_SET1_OFS + 12'hc, 32'h0);
    wr(WKO_CTRL_OFS, 32'hffff_ffff);
    chk(rs, WKO_RESP_OKAY);
    rc(WKO_CTRL_OFS, WKO_CTRL_RW_MASK);
    rd(12'h700);
    chk(rs, WKO_RESP_DECERR);
    wr(12'h700, 32'h1);
    chk(rs, WKO_RESP_DECERR);
    for (int i = 0; i < 4; i++)
    begin
      wr(WKO_SET0_OFS + 12'(4 * i), adr[32 * i +: 32]);
      wr(WKO_SET1_OFS + 12'(4 * i), tgt[32 * i +: 32]);
    end
    rc(WKO_SET0_OFS + 12'hc, adr[127:96]);
  endtask
  task automatic t_arp();
    dst = adr;
    wr(WKO_CTRL_OFS, 32'h0000_0004);
    frm(WKO_K_ARP, 5'b11110, 5'b10000); // bad checksum not counted
    rc(WKO_CTRL_OFS, 32'h0000_0004);
    wr(WKO_CTRL_OFS, 32'h8000_0004);
    frm(WKO_K_ARP, 5'b11110, 5'b01100);
    frm(WKO_K_ARP, 5'b11011, 5'b10000);
    rc(WKO_CTRL_OFS, 32'h8000_0044);
    wr(WKO_CTRL_OFS, 32'h8000_0440);
    rc(WKO_CTRL_OFS, 32'h8000_0400);
    frm(WKO_K_ARP, 5'b11111, 5'b10000);
    wr(WKO_CTRL_OFS, 32'h8000_0404);
    frm(WKO_K_ARP, 5'b11111, 5'b10100);
    frm(WKO_K_ARP, 5'b01111, 5'b10000);
    rc(WKO_CTRL_OFS, 32'h8000_0444);
  endtask
  task automatic t_ns();
    wr(WKO_CTRL_OFS, 32'h0000_0048);
    frm(WKO_K_NS, 5'b01111, 5'b01010);
    chk(o_result.ns_match, 2'h1);
    chk(o_result.na_src, tgt);
    wr(WKO_CTRL_OFS, 32'h0000_0388);
    rc(WKO_CTRL_OFS, 32'h0000_0308);
    dst = {WKO_SOLICIT_PFX, adr[127:104]};
    frm(WKO_K_NS, 5'b01111, 5'b10010);
    chk(o_result.na_src, adr);
    rc(WKO_CTRL_OFS, 32'h0000_0388);
    dst = tgt;
    frm(WKO_K_NS, 5'b01111, 5'b10010);
    chk(o_result.ns_match, 2'h2);
    frm(WKO_K_NS, 5'b10111, 5'b10000);
    wr(WKO_CTRL_OFS, 32'h0000_0380);
    frm(WKO_K_NS, 5'b11111, 5'b10000);
    chk(o_result.ns_match, 2'h0);
    // software clear and a new event land on the same edge
    fork
      wr(WKO_CTRL_OFS, 32'h0000_0380);
      frm(WKO_K_NS, 5'b11111, 5'b10000);
    join
    rc(WKO_CTRL_OFS, 32'h0000_0380);
  endtask
  task automatic t_syn();
    wr(WKO_CTRL_OFS, 32'h0000_0081);
    frm(WKO_K_V4_SYN, 5'b11111, 5'b10001);
    frm(WKO_K_V6_SYN, 5'b11111, 5'b10000);
    rc(WKO_CTRL_OFS, 32'h0000_0031);
    rsm();
    rc(WKO_CTRL_OFS, 32'h0000_0031);
    wr(WKO_RESUME_OFS, 32'h1);
    rsm();
    rc(WKO_CTRL_OFS, 32'h0000_0001);
    wr(WKO_CTRL_OFS, 32'h0000_0002);
    frm(WKO_K_V6_SYN, 5'b11111, 5'b10001);
    frm(WKO_K_V4_SYN, 5'b11111, 5'b10000);
    wr(WKO_RESUME_OFS, 32'h2);
    rsm();
    rc(WKO_CTRL_OFS, 32'h0000_0030);
  endtask

  initial
  begin
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_regs();
    t_arp();
    t_ns();
    t_syn();
    close_out();
  end
endmodule // wko_ctrl_tb_top
